// File: verilog/fts_cfg.svh
// Constants for the flow-through burst SRAM block
`ifndef FTS_CFG_SVH
`define FTS_CFG_SVH

`define FTS_ADDR_W        18
`define FTS_LANE_W        9
`define FTS_LANES         2
`define FTS_BURST_W       2
`define FTS_SYNC_STAGES   2
`define FTS_SLEEP_CYCLES  2
`define FTS_SLEEP_CNT_W   2
`define FTS_BEAT_FIRST    2'h0
`define FTS_BEAT_STEP     2'h1
`define FTS_LANES_NONE    2'h3
`define FTS_LANES_ALL     2'h3
`define FTS_ORDER_RST     1'b1
`define FTS_SYNC_RST      2'h0
`define FTS_SLEEP_SYNC_MSB 1

`endif

// File: verilog/fts_pkg.sv
// Types shared by the flow-through burst SRAM block
package fts_pkg;

  typedef enum logic [3:0] {
    FTS_ST_AWAKE = 4'h1,
    FTS_ST_ENTER = 4'h2,
    FTS_ST_SLEEP = 4'h4,
    FTS_ST_EXIT  = 4'h8
  } fts_sleep_t;

endpackage

// File: verilog/fts_mem.sv
// Lane-writable storage array with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "fts_cfg.svh"

module fts_mem #(
  parameter int ADDR_W = `FTS_ADDR_W,
  parameter int LANE_W = `FTS_LANE_W,
  parameter int LANES  = `FTS_LANES
) (
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  // Access
  input  wire logic [ADDR_W-1:0]       mem_addr,
  input  wire logic [LANES-1:0]        lane_we,
  input  wire logic [LANES*LANE_W-1:0] wr_data,
  output logic      [LANES*LANE_W-1:0] rd_data
);

  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      logic [LANE_W-1:0] store [0:(1<<ADDR_W)-1];

      // Contents carry no reset so sleep and reset never disturb them
      always_ff @(posedge ref_clk) begin
        if (lane_we[g]) begin
          store[mem_addr] <= wr_data[g*LANE_W +: LANE_W];
        end
      end

      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          rd_data[g*LANE_W +: LANE_W] <= '0;
        end else begin
          rd_data[g*LANE_W +: LANE_W] <= store[mem_addr];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// File: verilog/fts_sram_ctrl.sv
// Flow-through burst SRAM: access decode, burst counter, lane writes, sleep
// Function
// - Sample synchronous inputs on rising edge only
// - Start needs strobe low and all selects
// - Start loads address and two-bit burst counter
// - Advance input alone steps the burst counter
// - Strap low linear, high or open interleaved
// - Interleaved address is start XOR beat
// - Linear address increments and wraps modulo four
// - Read data follows the sampling edge
// - Controller-strobe read needs write inputs idle
// - Processor-strobe start ignores write inputs, reads
// - Write after processor start on next edge
// - Controller-strobe write stores data same cycle
// - Processor strobe low masks controller strobe
// - First select high masks processor strobe
// - Lane selects with byte enable write lanes
// - Global write writes every lane
// - Detected write floats data outputs, except at a processor-strobe start
// - Sleep entry and exit take two cycles
// - Contents kept; pending access dropped as invalid
// - Strobes idle, advance low: step and access
// - Strobes idle, advance high: repeat current address
// - Write when global low or enable plus lane
`timescale 1ns/1ps
`default_nettype none
`include "fts_cfg.svh"

module fts_sram_ctrl #(
  parameter int ADDR_W = `FTS_ADDR_W,
  parameter int LANE_W = `FTS_LANE_W,
  parameter int LANES  = `FTS_LANES
) (
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  // Address and selects
  input  wire logic [ADDR_W-1:0]       addr,
  input  wire logic                    chip_select_first_n,
  input  wire logic                    chip_select_second,
  input  wire logic                    chip_select_third_n,
  // Burst control
  input  wire logic                    proc_addr_strobe_n,
  input  wire logic                    ctrl_addr_strobe_n,
  input  wire logic                    burst_advance_n,
  // Write control
  input  wire logic                    global_write_n,
  input  wire logic                    byte_write_enable_n,
  input  wire logic [LANES-1:0]        byte_lane_select_n,
  // Asynchronous controls
  input  wire logic                    output_enable_n,
  input  wire logic                    sleep_request,
  input  wire logic                    burst_order,
  // Data pins, lane b above lane a, parity in each lane's top bit
  input  wire logic [LANES*LANE_W-1:0] data_in,
  output logic      [LANES*LANE_W-1:0] data_out,
  output logic                         data_oe,
  // Status
  output logic                         sleeping
);

  localparam int HI_W = ADDR_W - `FTS_BURST_W;

  // Burst address from start point and beat count
  function automatic logic [`FTS_BURST_W-1:0] burst_addr(
    input logic [`FTS_BURST_W-1:0] first,
    input logic [`FTS_BURST_W-1:0] beat,
    input logic                    interleave
  );
    logic [`FTS_BURST_W-1:0] res;
    if (interleave) begin
      res = first ^ beat;
    end else begin
      res = first + beat;
    end
    return res;
  endfunction

  // Sleep pin passes two flip-flops, strap pin three; the enable pin is not sampled
  logic [`FTS_SYNC_STAGES-1:0] sleep_sync_r;
  logic [`FTS_SYNC_STAGES-1:0] order_sync_r;
  logic                        sleep_s;
  logic                        interleave_r;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sleep_sync_r <= `FTS_SYNC_RST;
      // Open strap reads high, so a low reset value would fake linear order after reset
      order_sync_r <= {`FTS_SYNC_STAGES{`FTS_ORDER_RST}};
    end else begin
      sleep_sync_r <= {sleep_sync_r[`FTS_SYNC_STAGES-2:0], sleep_request};
      order_sync_r <= {order_sync_r[`FTS_SYNC_STAGES-2:0], burst_order};
    end
  end

  assign sleep_s = sleep_sync_r[`FTS_SLEEP_SYNC_MSB];

  // Strap is static; an open strap is pulled high outside, so reset picks interleaved
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      interleave_r <= `FTS_ORDER_RST;
    end else begin
      interleave_r <= order_sync_r[`FTS_SYNC_STAGES-1];
    end
  end

  // Sleep state machine
  fts_pkg::fts_sleep_t          sleep_st_r;
  fts_pkg::fts_sleep_t          sleep_st_nxt;
  logic [`FTS_SLEEP_CNT_W-1:0]  sleep_cnt_r;
  logic [`FTS_SLEEP_CNT_W-1:0]  sleep_cnt_nxt;
  logic                         awake;
  logic                         sleep_done;

  assign sleep_done = (sleep_cnt_r == `FTS_SLEEP_CNT_W'(`FTS_SLEEP_CYCLES - 1));

  always_comb begin
    sleep_st_nxt  = sleep_st_r;
    sleep_cnt_nxt = '0;
    case (sleep_st_r)
      fts_pkg::FTS_ST_AWAKE: begin
        if (sleep_s) begin
          sleep_st_nxt = fts_pkg::FTS_ST_ENTER;
        end
      end
      fts_pkg::FTS_ST_ENTER: begin
        if (sleep_done) begin
          sleep_st_nxt = fts_pkg::FTS_ST_SLEEP;
        end else begin
          sleep_cnt_nxt = sleep_cnt_r + `FTS_SLEEP_CNT_W'(1);
        end
      end
      fts_pkg::FTS_ST_SLEEP: begin
        if (!sleep_s) begin
          sleep_st_nxt = fts_pkg::FTS_ST_EXIT;
        end
      end
      fts_pkg::FTS_ST_EXIT: begin
        // Accesses stay masked here, which covers the recovery window
        if (sleep_done) begin
          sleep_st_nxt = fts_pkg::FTS_ST_AWAKE;
        end else begin
          sleep_cnt_nxt = sleep_cnt_r + `FTS_SLEEP_CNT_W'(1);
        end
      end
      default: begin
        sleep_st_nxt = fts_pkg::FTS_ST_AWAKE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sleep_st_r  <= fts_pkg::FTS_ST_AWAKE;
      sleep_cnt_r <= '0;
    end else begin
      sleep_st_r  <= sleep_st_nxt;
      sleep_cnt_r <= sleep_cnt_nxt;
    end
  end

  assign awake    = (sleep_st_r == fts_pkg::FTS_ST_AWAKE);
  assign sleeping = !awake;

  // Cycle decode on the values present at the rising edge
  logic                     cs_ok;
  logic                     proc_seen;
  logic                     ctrl_seen;
  logic                     write_ind;
  logic [LANES-1:0]         lane_wr;
  logic                     do_start;
  logic                     do_cont;
  logic                     do_write;
  logic                     do_desel;

  assign cs_ok     = !chip_select_first_n && chip_select_second && !chip_select_third_n;
  assign proc_seen = !proc_addr_strobe_n && !chip_select_first_n;
  assign ctrl_seen = !ctrl_addr_strobe_n && !proc_seen;
  assign write_ind = !global_write_n ||
                     (!byte_write_enable_n && (byte_lane_select_n != `FTS_LANES_NONE));

  always_comb begin
    if (!global_write_n) begin
      lane_wr = `FTS_LANES_ALL;
    end else if (!byte_write_enable_n) begin
      lane_wr = ~byte_lane_select_n;
    end else begin
      lane_wr = '0;
    end
  end

  logic                     selected_r;
  logic                     read_valid_r;
  logic [HI_W-1:0]          addr_hi_r;
  logic [`FTS_BURST_W-1:0]  first_r;
  logic [`FTS_BURST_W-1:0]  beat_r;
  logic [`FTS_BURST_W-1:0]  beat_nxt;
  logic [ADDR_W-1:0]        mem_addr;
  logic [LANES-1:0]         mem_we;

  always_comb begin
    do_start = 1'b0;
    do_cont  = 1'b0;
    do_write = 1'b0;
    do_desel = 1'b0;
    if (!awake) begin
      do_desel = 1'b1;
    end else if (proc_seen) begin
      do_start = cs_ok;
      do_desel = !cs_ok;
    end else if (ctrl_seen) begin
      do_start = cs_ok;
      do_write = cs_ok && write_ind;
      do_desel = !cs_ok;
    end else if (selected_r) begin
      do_cont  = 1'b1;
      do_write = write_ind;
    end
  end

  always_comb begin
    if (do_start) begin
      beat_nxt = `FTS_BEAT_FIRST;
    end else if (do_cont && !burst_advance_n) begin
      beat_nxt = beat_r + `FTS_BEAT_STEP;
    end else begin
      beat_nxt = beat_r;
    end
  end

  // Later beats take their low bits from the counter, not the pins
  always_comb begin
    if (do_start) begin
      mem_addr = addr;
    end else begin
      mem_addr = {addr_hi_r, burst_addr(first_r, beat_nxt, interleave_r)};
    end
  end

  assign mem_we = do_write ? lane_wr : '0;

  // Address register and burst counter
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      addr_hi_r <= '0;
      first_r   <= '0;
      beat_r    <= '0;
    end else if (do_start) begin
      addr_hi_r <= addr[ADDR_W-1:`FTS_BURST_W];
      first_r   <= addr[`FTS_BURST_W-1:0];
      beat_r    <= `FTS_BEAT_FIRST;
    end else if (do_cont) begin
      beat_r    <= beat_nxt;
    end
  end

  // Selection and read-drive state
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      selected_r   <= 1'b0;
      read_valid_r <= 1'b0;
    end else if (do_desel) begin
      selected_r   <= 1'b0;
      read_valid_r <= 1'b0;
    end else if (do_start || do_cont) begin
      selected_r   <= 1'b1;
      read_valid_r <= !do_write;
    end else begin
      read_valid_r <= 1'b0;
    end
  end

  // Read data settles right after the same edge that samples the address
  fts_mem #(
    .ADDR_W (ADDR_W),
    .LANE_W (LANE_W),
    .LANES  (LANES)
  ) u_mem (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .mem_addr (mem_addr),
    .lane_we  (mem_we),
    .wr_data  (data_in),
    .rd_data  (data_out)
  );

  // Enable pin is unsampled so a release is seen at once
  assign data_oe = read_valid_r && !output_enable_n && awake;

endmodule
`default_nettype wire

// File: test/fts_sram_chk.sv
// Port assertions for the burst SRAM control block
`timescale 1ns/1ps
`default_nettype none
module fts_sram_chk #(
  parameter int LANES = 2
) (
  // Clock and reset
  input wire logic             ref_clk,
  input wire logic             rst,
  // Selects and strobes
  input wire logic             chip_select_first_n,
  input wire logic             chip_select_second,
  input wire logic             chip_select_third_n,
  input wire logic             proc_addr_strobe_n,
  input wire logic             ctrl_addr_strobe_n,
  // Write and async controls
  input wire logic             global_write_n,
  input wire logic             byte_write_enable_n,
  input wire logic [LANES-1:0] byte_lane_select_n,
  input wire logic             output_enable_n,
  input wire logic             sleep_request,
  // Outputs
  input wire logic             data_oe,
  input wire logic             sleeping
);
  logic [1:0] quiet_r;
  logic       sel_ok;
  logic       wr_ind;
  logic       awake;
  assign sel_ok = !chip_select_first_n && chip_select_second && !chip_select_third_n;
  assign wr_ind = !global_write_n || (!byte_write_enable_n && !(&byte_lane_select_n));
  assign awake  = (quiet_r == 2'h3);
  // Near a sleep request the synchroniser may mask a start
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      quiet_r <= 2'h0;
    end else if (sleep_request || sleeping) begin
      quiet_r <= 2'h0;
    end else if (!awake) begin
      quiet_r <= quiet_r + 2'h1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  oe_gate_a: assert property (output_enable_n |-> !data_oe)
    else $error("driving with enable high");
  sleep_float_a: assert property (sleeping |-> !data_oe)
    else $error("driving while asleep");
  ctrl_write_a: assert property (sel_ok && !ctrl_addr_strobe_n && proc_addr_strobe_n && wr_ind && awake |=> !data_oe)
    else $error("driving after write");
  proc_read_a: assert property (sel_ok && !proc_addr_strobe_n && awake |=> data_oe || output_enable_n)
    else $error("processor start not read");
  ctrl_read_a: assert property (sel_ok && !ctrl_addr_strobe_n && !wr_ind && awake |=> data_oe || output_enable_n)
    else $error("controller read missing");
  desel_float_a: assert property ((!ctrl_addr_strobe_n || (!proc_addr_strobe_n && !chip_select_first_n)) && !sel_ok
    |=> !data_oe)
    else $error("driving when deselected");
  sleep_enter_a: assert property (sleep_request [*5] |-> sleeping)
    else $error("sleep entry late");
  sleep_exit_a: assert property (!sleep_request [*7] |-> !sleeping)
    else $error("sleep exit late");
endmodule
bind fts_sram_ctrl fts_sram_chk #(.LANES(LANES)) u_chk (
  .ref_clk(ref_clk), .rst(rst), .chip_select_first_n(chip_select_first_n),
  .chip_select_second(chip_select_second), .chip_select_third_n(chip_select_third_n),
  .proc_addr_strobe_n(proc_addr_strobe_n), .ctrl_addr_strobe_n(ctrl_addr_strobe_n),
  .global_write_n(global_write_n), .byte_write_enable_n(byte_write_enable_n),
  .byte_lane_select_n(byte_lane_select_n), .output_enable_n(output_enable_n),
  .sleep_request(sleep_request), .data_oe(data_oe), .sleeping(sleeping)
);
`default_nettype wire

// File: test/fts_host_model.sv
// Host side of the shared data lines
`timescale 1ns/1ps
`default_nettype none
module fts_host_model (
  // Clock
  input wire logic        ref_clk,
  // Device side
  input wire logic [17:0] data_out,
  input wire logic        data_oe,
  // Host side
  input wire logic        drive_en,
  input wire logic [17:0] drive_data,
  output logic     [17:0] bus,
  output logic            clash
);
  logic [17:0] last_r = 18'h0;
  // Released lines toggle, so a stale value never passes
  assign bus   = data_oe ? data_out : (drive_en ? drive_data : ~last_r);
  assign clash = data_oe && drive_en;
  always_ff @(posedge ref_clk) begin
    last_r <= bus;
  end
endmodule
`default_nettype wire

// File: test/tb_top.sv
// Self-checking bench for the burst SRAM control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_top;
  localparam logic [17:0] BASE = 18'h01230;
  // Bench state
  logic        ref_clk = 0;
  logic        rst = 1;
  int          n_errors = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  // Stimulus and observed
  logic [17:0] addr, bus_d, data_in, data_out;
  logic [1:0]  lane_n;
  logic        sel1_n, sel2, sel3_n, ps_n, cs_n, step_n, glob_n, ben_n;
  logic        oe_n, sleep_req, mode, den, data_oe, sleeping, clash;
  fts_sram_ctrl DUT (
    .ref_clk(ref_clk), .rst(rst), .addr(addr), .chip_select_first_n(sel1_n),
    .chip_select_second(sel2), .chip_select_third_n(sel3_n), .proc_addr_strobe_n(ps_n),
    .ctrl_addr_strobe_n(cs_n), .burst_advance_n(step_n), .global_write_n(glob_n),
    .byte_write_enable_n(ben_n), .byte_lane_select_n(lane_n), .output_enable_n(oe_n),
    .sleep_request(sleep_req), .burst_order(mode), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .sleeping(sleeping)
  );
  fts_host_model u_host (
    .ref_clk(ref_clk), .data_out(data_out), .data_oe(data_oe),
    .drive_en(den), .drive_data(bus_d), .bus(data_in), .clash(clash)
  );
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 1000) begin
      n_errors++;
      conclude;
    end
  end
  function automatic logic [17:0] pat(input logic [17:0] a);
    return {a[8:0] ^ 9'h0A5, a[8:0]};
  endfunction
  task automatic idle;
    // Selected, strobes idle, no write, host released
    {ps_n, cs_n, step_n, glob_n, ben_n, den, oe_n, sel1_n, sel2, sel3_n} = 10'h3E2;
    lane_n = 2'h3;
  endtask
  task automatic wr(input logic [17:0] a);
    // Only lane a selected: global write must still fill both
    {addr, bus_d, cs_n, glob_n, ben_n, lane_n, den} = {a, pat(a), 6'h05};
    @(negedge ref_clk);
    `CHK("write oe", 1'b0, data_oe)
    `CHK("clash", 1'b0, clash)
  endtask
  task automatic rd1(input logic [17:0] a, input logic [17:0] e);
    {addr, ps_n} = {a, 1'b0};
    @(negedge ref_clk);
    ps_n = 1;
    `CHK("read data", e, data_out)
    oe_n = 1;
    #1;
    `CHK("oe float", 1'b0, data_oe)
    oe_n = 0;
  endtask
  task automatic burst(input logic use_ps, input logic [17:0] a);
    logic [1:0] w;
    {addr, ps_n, cs_n, step_n, ben_n, lane_n} = {a, !use_ps, use_ps, 4'h4};
    for (int b = 0; b < 4; b++) begin
      @(negedge ref_clk);
      w = mode ? a[1:0] ^ 2'(b) : a[1:0] + 2'(b);
      `CHK("burst data", pat({a[17:2], w}), data_out)
      `CHK("burst oe", 1'b1, data_oe)
      {addr, ps_n, cs_n} = {~a, 2'h3};
    end
    step_n = 1;
    @(negedge ref_clk);
    `CHK("suspend", pat({a[17:2], w}), data_out)
    $display("burst order %0d done", mode);
  endtask
  task automatic proc_write(input logic [17:0] a);
    logic [17:0] e;
    e = pat(a);
    e[8:0] = 9'h1FF;
    {addr, ps_n, glob_n} = {a, 2'h0};
    @(negedge ref_clk);
    `CHK("start read", pat(a), data_out)
    // Enable released with the data so the read drivers let go first
    {ps_n, glob_n, ben_n, lane_n, den, oe_n, bus_d} = {7'h6B, 18'h3FFFF};
    #1;
    `CHK("clash", 1'b0, clash)
    @(negedge ref_clk);
    idle;
    #1;
    `CHK("write float", 1'b0, data_oe)
    @(negedge ref_clk);
    rd1(a, e);
    $display("processor write done");
  endtask
  task automatic prio(input logic [17:0] a);
    {addr, ps_n, cs_n, glob_n} = {a, 3'h0};
    @(negedge ref_clk);
    `CHK("both strobes", pat(a), data_out)
    {sel1_n, cs_n, glob_n} = 3'h7;
    @(negedge ref_clk);
    `CHK("ignored strobe", pat(a), data_out)
    `CHK("ignored oe", 1'b1, data_oe)
    cs_n = 0;
    @(negedge ref_clk);
    `CHK("masked", 1'b0, data_oe)
    idle;
    @(negedge ref_clk);
    `CHK("deselected", 1'b0, data_oe)
    rd1(a, pat(a));
    $display("strobe priority done");
  endtask
  task automatic sleep_test;
    {cs_n, sel2} = 2'h0;
    @(negedge ref_clk);
    `CHK("deselect", 1'b0, data_oe)
    {cs_n, sel1_n, sel3_n, sleep_req} = 4'hF;
    repeat (6) @(negedge ref_clk);
    `CHK("asleep", 1'b1, sleeping)
    `CHK("asleep oe", 1'b0, data_oe)
    sleep_req = 0;
    repeat (8) @(negedge ref_clk);
    `CHK("awake", 1'b0, sleeping)
    idle;
    @(negedge ref_clk);
    rd1(BASE, pat(BASE));
    $display("sleep done");
  endtask
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    {addr, bus_d, mode, sleep_req} = {36'h0, 2'h2};
    idle;
    repeat (4) @(negedge ref_clk);
    `CHK("reset oe", 1'b0, data_oe)
    `CHK("reset sleep", 1'b0, sleeping)
    rst = 0;
    for (int i = 0; i < 4; i++) wr(BASE + 18'(i));
    $display("writes done");
    idle;
    @(negedge ref_clk);
    burst(1, BASE + 18'h1);
    mode = 0;
    idle;
    repeat (5) @(negedge ref_clk);
    burst(0, BASE + 18'h3);
    idle;
    @(negedge ref_clk);
    proc_write(BASE + 18'h2);
    prio(BASE + 18'h3);
    sleep_test;
    conclude;
  end
endmodule
`default_nettype wire
